// ### design/sxa_signaling_extractor.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module sxa_signaling_extractor
	import sxa_pkg::*;
(
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic [11:0]     awaddr,
	input  wire logic            awvalid,
	output logic                 awready,
	input  wire logic [31:0]     wdata,
	input  wire logic [3:0]      wstrb,
	input  wire logic            wvalid,
	output logic                 wready,
	output logic [1:0]           bresp,
	output logic                 bvalid,
	input  wire logic            bready,
	input  wire logic [11:0]     araddr,
	input  wire logic            arvalid,
	output logic                 arready,
	output logic [31:0]          rdata,
	output logic [1:0]           rresp,
	output logic                 rvalid,
	input  wire logic            rready,
	input  wire sxa_sig_type     sig_in,
	input  wire logic            mf_tick,
	input  wire sxa_pcm_in_type  pcm_in,
	input  wire logic [31:0]     sign_invert_ctl,
	output sxa_pcm_out_type      pcm_out,
	output logic                 interrupt_out_n
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic [7:0]        cfg_r;
	logic              e1_r;
	logic [7:0]        actl_r;
	logic [7:0]        data_r;
	logic [30:1]       flags_r;
	logic [30:1]       set_vec;
	logic [30:1]       clr_vec;
	logic              awready_r;
	logic              aw_got_r;
	logic [11:0]       awaddr_r;
	logic              wready_r;
	logic              w_got_r;
	logic [7:0]        wbyte_r;
	logic              wlane_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              arready_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic              irq_n_r;
	sxa_pcm_out_type   pcm_out_r;
	sxa_ia_state_type  ia_state_r;
	logic [2:0]        ia_cnt_r;
	logic [7:0]        op_r;
	logic              busy;
	logic              view_ev;
	logic              pch_en;
	logic              wr_do;
	logic [7:0]        wr_idx;
	logic              wr_map;
	logic              ia_start;
	logic              ia_last;
	logic              ind_wr_cfg;
	logic              ar_do;
	logic [7:0]        ar_idx;
	logic              ar_map;
	logic [7:0]        rd_val;
	logic [7:0]        ind_rdata;
	logic [3:0]        cur_r [32];
	logic [3:0]        prev_r [32];
	logic [3:0]        stage_r [32];
	logic [3:0]        dly_r [32];
	logic [3:0]        ptcfg_r [32];
	logic              sig_ok;
	logic [3:0]        sig_cfg;
	logic [3:0]        new_nib;
	logic              sig_chg;
	logic [4:0]        flag_pos;
	logic [3:0]        pcm_cfg;
	logic [7:0]        pcm_d;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	assign view_ev = cfg_r[CFG_VIEW_BIT];
	assign pch_en  = cfg_r[CFG_PCH_EN_BIT];
	assign busy    = (ia_state_r == IA_BUSY);

	// ****************************************************************
	// Bus slave: write channels.
	// ****************************************************************
	// Address and data are latched independently so either order works.
	assign wr_do  = aw_got_r && w_got_r && !bvalid_r;
	assign wr_idx = awaddr_r[9:2];
	assign wr_map = (awaddr_r[11:10] == 2'b00) && ((wr_idx == IDX_CFG) || (wr_idx == IDX_STAT)
		|| (wr_idx == IDX_ACTL) || (wr_idx == IDX_DATA) || (wr_idx == IDX_MODE));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			aw_got_r  <= 1'b0;
			awaddr_r  <= 12'h000;
			wready_r  <= 1'b1;
			w_got_r   <= 1'b0;
			wbyte_r   <= 8'h00;
			wlane_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (awvalid && awready_r) begin
				awready_r <= 1'b0;
				aw_got_r  <= 1'b1;
				awaddr_r  <= awaddr;
			end
			if (wvalid && wready_r) begin
				wready_r <= 1'b0;
				w_got_r  <= 1'b1;
				wbyte_r  <= wdata[7:0];
				wlane_r  <= wstrb[0];
			end
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_r && bready) begin
				bvalid_r  <= 1'b0;
				aw_got_r  <= 1'b0;
				w_got_r   <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Start an indirect access only for a mapped indirect location while idle.
	assign ia_start = wr_do && wlane_r && !view_ev && (wr_idx == IDX_ACTL) && (awaddr_r[11:10] == 2'b00)
		&& (ia_state_r == IA_IDLE) && (wbyte_r[6:0] >= IND_CUR_BASE) && (wbyte_r[6:0] <= IND_CFG_END);

	// ****************************************************************
	// Software registers.
	// ****************************************************************
	// In the event view only the view select bit of the configuration register and the mode register are writable.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r  <= CFG_RST;
			e1_r   <= 1'b0;
			actl_r <= ACTL_RST;
		end else if (wr_do && wlane_r && (awaddr_r[11:10] == 2'b00)) begin
			if (wr_idx == IDX_CFG) begin
				if (view_ev) begin
					cfg_r[CFG_VIEW_BIT] <= wbyte_r[CFG_VIEW_BIT];
				end else begin
					cfg_r <= wbyte_r;
				end
			end
			if (wr_idx == IDX_MODE) begin
				e1_r <= wbyte_r[MODE_E1_BIT];
			end
			if ((wr_idx == IDX_ACTL) && !view_ev) begin
				actl_r <= wbyte_r;
			end
		end
	end

	// Data buffer: loaded by software, or by the end of an indirect read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_r <= DATA_RST;
		end else if (ia_last && op_r[ACTL_RNW_BIT]) begin
			data_r <= ind_rdata;
		end else if (wr_do && wlane_r && !view_ev && (wr_idx == IDX_DATA) && (awaddr_r[11:10] == 2'b00)) begin
			data_r <= wbyte_r;
		end
	end

	// ****************************************************************
	// Indirect access sequencer.
	// ****************************************************************
	// The operation is latched so a stray control write cannot alter a running access.
	assign ia_last    = busy && (ia_cnt_r == 3'd0);
	assign ind_wr_cfg = ia_last && !op_r[ACTL_RNW_BIT] && (op_r[6:0] >= IND_CFG_BASE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ia_state_r <= IA_IDLE;
			ia_cnt_r   <= 3'd0;
			op_r       <= ACTL_RST;
		end else begin
			unique case (ia_state_r)
				IA_IDLE: begin
					if (ia_start) begin
						ia_state_r <= IA_BUSY;
						ia_cnt_r   <= IND_BUSY_CYC - 3'd1;
						op_r       <= wbyte_r;
					end
				end
				IA_BUSY: begin
					if (ia_cnt_r == 3'd0) begin
						ia_state_r <= IA_IDLE;
					end else begin
						ia_cnt_r <= ia_cnt_r - 3'd1;
					end
				end
			endcase
		end
	end

	// Indirect read decode; unavailable nibbles read as zero.
	always_comb begin
		ind_rdata = 8'h00;
		if ((op_r[6:0] >= IND_CUR_BASE) && (op_r[6:0] < IND_DLY_BASE)) begin
			if (!(e1_r && (op_r[3:0] == 4'h0))) begin
				ind_rdata[7:4] = cur_r[{1'b0, op_r[3:0]}];
			end
			if (!(e1_r && (op_r[3:0] == 4'h0)) && (e1_r || (op_r[3:0] < 4'h8))) begin
				ind_rdata[3:0] = cur_r[{1'b1, op_r[3:0]}];
			end
		end else if ((op_r[6:0] >= IND_DLY_BASE) && (op_r[6:0] < IND_CFG_BASE)) begin
			if (e1_r || (op_r[4:0] <= T1_LAST_IDX)) begin
				ind_rdata[3:0] = dly_r[op_r[4:0]];
			end
		end else if (op_r[6:0] >= IND_CFG_BASE) begin
			ind_rdata[3:0] = ptcfg_r[op_r[4:0]];
		end
	end

	// ****************************************************************
	// Bus slave: read channel.
	// ****************************************************************
	assign ar_do  = arvalid && arready_r;
	assign ar_idx = araddr[9:2];
	assign ar_map = (araddr[11:10] == 2'b00) && ((ar_idx == IDX_CFG) || (ar_idx == IDX_STAT)
		|| (ar_idx == IDX_ACTL) || (ar_idx == IDX_DATA) || (ar_idx == IDX_MODE));

	// The view select bit swaps flag registers in over the indirect ones.
	always_comb begin
		rd_val  = 8'h00;
		clr_vec = '0;
		if (ar_map) begin
			unique case (ar_idx)
				IDX_CFG: begin
					rd_val = view_ev ? {2'b01, flags_r[30:25]} : cfg_r;
					if (view_ev && ar_do) clr_vec[30:25] = 6'h3f;
				end
				IDX_STAT: begin
					rd_val = view_ev ? flags_r[24:17] : {busy, 7'h00};
					if (view_ev && ar_do) clr_vec[24:17] = 8'hff;
				end
				IDX_ACTL: begin
					rd_val = view_ev ? flags_r[16:9] : actl_r;
					if (view_ev && ar_do) clr_vec[16:9] = 8'hff;
				end
				IDX_DATA: begin
					rd_val = view_ev ? flags_r[8:1] : data_r;
					if (view_ev && ar_do) clr_vec[8:1] = 8'hff;
				end
				default: begin
					rd_val = {7'h00, e1_r};
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= RESP_OKAY;
		end else if (ar_do) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= {24'h00_0000, rd_val};
			rresp_r   <= ar_map ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// ****************************************************************
	// Signaling capture and change flags.
	// ****************************************************************
	// E1 timeslots 0 and 16 and T1 entries past channel 24 never register a change.
	assign sig_ok  = e1_r ? ((sig_in.chan != 5'd0) && (sig_in.chan != E1_SIG_TS))
		: (sig_in.chan <= T1_LAST_IDX);
	assign sig_cfg = pch_en ? ptcfg_r[sig_in.chan] : 4'h0;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			if (sig_cfg[PT_DEB_BIT] && (sig_in.abcd[b] != prev_r[sig_in.chan][b])) begin
				new_nib[b] = cur_r[sig_in.chan][b];
			end else begin
				new_nib[b] = sig_in.abcd[b];
			end
		end
	end

	assign sig_chg  = sig_in.valid && sig_ok && (new_nib != cur_r[sig_in.chan]);
	// T1 channel n sits at index n-1; E1 flags skip timeslot 16.
	assign flag_pos = e1_r ? ((sig_in.chan < E1_SIG_TS) ? sig_in.chan : sig_in.chan - 5'd1)
		: sig_in.chan + 5'd1;

	genvar k;
	generate
		for (k = 0; k < 32; k++) begin : g_entry
			if ((k >= 1) && (k <= 30)) begin : g_flag
				assign set_vec[k] = sig_chg && (flag_pos == 5'(k));
			end
			// Current data updates at once, so it is readable with its flag.
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cur_r[k]  <= 4'h0;
					prev_r[k] <= 4'h0;
				end else if (sig_in.valid && sig_ok && (sig_in.chan == 5'(k))) begin
					cur_r[k]  <= new_nib;
					prev_r[k] <= sig_in.abcd;
				end
			end
			// Two multiframe stages give the one-multiframe lag of the delayed copy.
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					stage_r[k] <= 4'h0;
					dly_r[k]   <= 4'h0;
				end else if (mf_tick) begin
					stage_r[k] <= cur_r[k];
					dly_r[k]   <= stage_r[k];
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ptcfg_r[k] <= 4'h0;
				end else if (ind_wr_cfg && (op_r[4:0] == 5'(k))) begin
					ptcfg_r[k] <= data_r[3:0];
				end
			end
		end
	endgenerate

	// A set in the same cycle as the clearing read survives.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_r & ~clr_vec) | set_vec;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= !(cfg_r[CFG_IRQ_EN_BIT] && (|flags_r));
		end
	end

	// ****************************************************************
	// Receive data conditioning.
	// ****************************************************************
	// Fixing first, then inversion, then trunk code, then milliwatt on top.
	assign pcm_cfg = pch_en ? ptcfg_r[pcm_in.ts] : 4'h0;

	always_comb begin
		pcm_d = pcm_in.data;
		if (e1_r) begin
			unique case (pcm_cfg[PT_INV1_BIT:PT_FIX_BIT])
				2'b01:   pcm_d = pcm_d ^ MASK_EVEN;
				2'b10:   pcm_d = pcm_d ^ MASK_ODD;
				2'b11:   pcm_d = ~pcm_d;
				default: pcm_d = pcm_d;
			endcase
		end else begin
			if (pcm_cfg[PT_FIX_BIT] && pcm_in.sigframe) begin
				pcm_d[0] = pcm_cfg[PT_POL_BIT];
			end
			unique case ({pcm_cfg[PT_INV1_BIT], sign_invert_ctl[pcm_in.ts]})
				2'b10:   pcm_d = ~pcm_d;
				2'b01:   pcm_d = pcm_d ^ MASK_SIGN;
				2'b11:   pcm_d = pcm_d ^ MASK_MAG;
				default: pcm_d = pcm_d;
			endcase
		end
		if (pcm_in.trunk) begin
			pcm_d = TRUNK_CODE;
		end
		if (pcm_in.mw) begin
			pcm_d = pcm_in.mw_byte;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcm_out_r <= '0;
		end else begin
			pcm_out_r.valid <= pcm_in.valid;
			pcm_out_r.data  <= pcm_d;
		end
	end

	assign awready         = awready_r;
	assign wready          = wready_r;
	assign bvalid          = bvalid_r;
	assign bresp           = bresp_r;
	assign arready         = arready_r;
	assign rvalid          = rvalid_r;
	assign rdata           = rdata_r;
	assign rresp           = rresp_r;
	assign pcm_out         = pcm_out_r;
	assign interrupt_out_n = irq_n_r;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	a_flag_set_kept: assert property (|set_vec |=> ((flags_r & $past(set_vec)) == $past(set_vec)))
		else $error("change flag lost");
	a_flag_mid_clear: assert property (ar_do && view_ev && (ar_idx == IDX_ACTL) && ar_map && (set_vec[16:9] == 8'h00)
		|=> (flags_r[16:9] == 8'h00))
		else $error("middle flags not cleared by read");
	a_busy_span: assert property (ia_start |=> busy [*4] ##1 !busy)
		else $error("busy duration wrong");
	a_ind_read_data: assert property (ia_last && op_r[ACTL_RNW_BIT] |=> (data_r == $past(ind_rdata)) && !busy)
		else $error("indirect read data missing");
	a_ind_write_cfg: assert property (ind_wr_cfg |=> (ptcfg_r[$past(op_r[4:0])] == $past(data_r[3:0])))
		else $error("indirect write not stored");
	a_irq_gate: assert property (!cfg_r[CFG_IRQ_EN_BIT] |=> interrupt_out_n)
		else $error("interrupt raised while disabled");
	a_e1_skip: assert property (sig_in.valid && e1_r && ((sig_in.chan == 5'd0) || (sig_in.chan == E1_SIG_TS))
		|-> (set_vec == '0))
		else $error("flag for timeslot without signaling");
	a_e1_invert_all: assert property (pcm_in.valid && e1_r && pch_en && !pcm_in.trunk && !pcm_in.mw
		&& (ptcfg_r[pcm_in.ts][PT_INV1_BIT:PT_FIX_BIT] == 2'b11) |=> (pcm_out.data == ~$past(pcm_in.data)))
		else $error("E1 full inversion wrong");
	a_pch_en_gate: assert property (pcm_in.valid && e1_r && !pch_en && !pcm_in.trunk && !pcm_in.mw
		|=> (pcm_out.data == $past(pcm_in.data)))
		else $error("conditioning active while disabled");

endmodule

// ### design/sxa_pkg.sv
package sxa_pkg;

	// ****************************************************************
	// Register indices on the bus (byte address is four times these).
	// ****************************************************************
	localparam logic [7:0] IDX_CFG  = 8'h50;
	localparam logic [7:0] IDX_STAT = 8'h51;
	localparam logic [7:0] IDX_ACTL = 8'h52;
	localparam logic [7:0] IDX_DATA = 8'h53;
	localparam logic [7:0] IDX_MODE = 8'h60;

	// Register fields and reset values.
	localparam int unsigned CFG_VIEW_BIT   = 6;
	localparam int unsigned CFG_IRQ_EN_BIT = 5;
	localparam int unsigned CFG_PCH_EN_BIT = 0;
	localparam logic [7:0]  CFG_RST      = 8'h00;
	localparam logic [7:0]  ACTL_RST     = 8'h00;
	localparam logic [7:0]  DATA_RST     = 8'h00;
	localparam int unsigned ACTL_RNW_BIT = 7;
	localparam int unsigned STAT_BUSY_BIT = 7;
	localparam int unsigned MODE_E1_BIT  = 0;

	// ****************************************************************
	// Indirect address space.
	// ****************************************************************
	localparam logic [6:0] IND_CUR_BASE = 7'h10;
	localparam logic [6:0] IND_DLY_BASE = 7'h20;
	localparam logic [6:0] IND_CFG_BASE = 7'h40;
	localparam logic [6:0] IND_CFG_END  = 7'h5f;
	localparam logic [4:0] T1_LAST_IDX  = 5'd23;
	localparam logic [4:0] E1_SIG_TS    = 5'd16;

	// Per-timeslot configuration fields.
	localparam int unsigned PT_INV1_BIT = 3;
	localparam int unsigned PT_FIX_BIT  = 2;
	localparam int unsigned PT_POL_BIT  = 1;
	localparam int unsigned PT_DEB_BIT  = 0;

	// Indirect access duration in clock cycles.
	localparam logic [2:0] IND_BUSY_CYC = 3'd4;

	// Data conditioning masks; bit 1 of a timeslot is the MSB.
	localparam logic [7:0] MASK_ODD   = 8'haa;
	localparam logic [7:0] MASK_EVEN  = 8'h55;
	localparam logic [7:0] MASK_SIGN  = 8'h80;
	localparam logic [7:0] MASK_MAG   = 8'h7f;
	localparam logic [7:0] TRUNK_CODE = 8'hff;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef enum logic [1:0] {
		IA_IDLE = 2'b00,
		IA_BUSY = 2'b01
	} sxa_ia_state_type;

	typedef struct packed {
		logic       valid;
		logic [4:0] chan;
		logic [3:0] abcd;
	} sxa_sig_type;

	typedef struct packed {
		logic       valid;
		logic [4:0] ts;
		logic       sigframe;
		logic       trunk;
		logic       mw;
		logic [7:0] mw_byte;
		logic [7:0] data;
	} sxa_pcm_in_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} sxa_pcm_out_type;

endpackage

// ### test/sxa_host_model.sv
`timescale 1ns/100ps
module sxa_host_model
	import sxa_pkg::*;
(
	input  wire logic        aclk,
	output logic [11:0]      awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [11:0]      araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);

	// Idle bus at time zero.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// ****************************************************************
	// Bus cycles; payloads are scrambled once taken so stale values never help.
	// ****************************************************************
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		logic aw_now;
		logic w_now;
		aw_done = 1'b0;
		w_done  = 1'b0;
		@(posedge aclk);
		awaddr  <= {2'b00, idx, 2'b00};
		wdata   <= {24'h000000, d};
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		// Each channel is released at the edge that takes it, so either order works.
		while (!(aw_done && w_done)) begin
			@(negedge aclk);
			aw_now = !aw_done && (awready === 1'b1);
			w_now  = !w_done && (wready === 1'b1);
			@(posedge aclk);
			if (aw_now) begin
				awvalid <= 1'b0;
				awaddr  <= ~awaddr;
			end
			if (w_now) begin
				wvalid <= 1'b0;
				wdata  <= ~wdata;
			end
			aw_done = aw_done || aw_now;
			w_done  = w_done || w_now;
		end
		do
			@(negedge aclk);
		while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr  <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
			@(negedge aclk);
		while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		araddr  <= ~araddr;
		do
			@(negedge aclk);
		while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Indirect access; busy is polled so a second request never overlaps the first.
	task automatic ind(input logic rnw, input logic [6:0] a, inout logic [7:0] d);
		logic [1:0] r;
		logic [7:0] s;
		if (!rnw)
			wr(IDX_DATA, d, r);
		wr(IDX_ACTL, {rnw, a}, r);
		s = 8'h80;
		while (s[STAT_BUSY_BIT] !== 1'b0)
			rd(IDX_STAT, s, r);
		rd(IDX_DATA, d, r);
	endtask

endmodule

// ### test/test_signaling_extractor_access.sv
`timescale 1ns/100ps
module test_signaling_extractor_access import sxa_pkg::*;;

	logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic            arvalid, arready, rvalid, rready, mf_tick, interrupt_out_n;
	logic [11:0]     awaddr, araddr;
	logic [31:0]     wdata, rdata, sign_invert_ctl;
	logic [3:0]      wstrb;
	logic [1:0]      bresp, rresp, r;
	sxa_sig_type     sig_in;
	sxa_pcm_in_type  pcm_in, p;
	sxa_pcm_out_type pcm_out;
	logic [3:0]      cur_m [32];
	logic [7:0]      v, cv;
	int              failures, checked, cyc, seed, md, en, i, k, ch, pos;

	sxa_signaling_extractor uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .sig_in, .mf_tick, .pcm_in, .sign_invert_ctl, .pcm_out, .interrupt_out_n);
	sxa_host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	// Clock and a hang guard that ends the run as a failure.
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			print_verdict();
		end
	end

	// ****************************************************************
	// Checking helpers.
	// ****************************************************************
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Expected conditioned byte: fixing first, then inversion, trunk, milliwatt.
	function automatic logic [7:0] pexp(input logic e1, input logic [3:0] c, input logic s,
		input sxa_pcm_in_type q);
		logic [7:0] d;
		logic [7:0] m;
		d = q.data;
		if (!e1 && c[PT_FIX_BIT] && q.sigframe)
			d[0] = c[PT_POL_BIT];
		if (e1)
			m = (c[3] ? MASK_ODD : 8'h00) | (c[2] ? MASK_EVEN : 8'h00);
		else
			m = c[3] ? (s ? MASK_MAG : 8'hff) : (s ? MASK_SIGN : 8'h00);
		d = d ^ m;
		if (q.trunk)
			d = TRUNK_CODE;
		if (q.mw)
			d = q.mw_byte;
		return d;
	endfunction

	// ****************************************************************
	// Main sequence: T1 pass, then E1 pass.
	// ****************************************************************
	initial begin
		seed = 95298;
		{aclk, aresetn, mf_tick, sig_in, pcm_in} = '0;
		sign_invert_ctl = $random(seed);
		{failures, checked, cyc} = '0;
		foreach (cur_m[j])
			cur_m[j] = 4'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		host.rd(IDX_CFG, v, r);
		chk("config reset", v, CFG_RST);
		host.rd(IDX_ACTL, v, r);
		chk("addr ctl reset", v, ACTL_RST);
		host.rd(8'h7f, v, r);
		chk("unmapped read", r, RESP_SLVERR);
		host.wr(8'h7e, 8'h00, r);
		chk("unmapped write", r, RESP_SLVERR);
		for (md = 0; md < 2; md++) begin
			host.wr(IDX_MODE, 8'(md), r);
			host.wr(IDX_CFG, 8'h23, r);
			for (i = 0; i < 4; i++) begin
				ch = md ? $unsigned($random(seed)) % 31 + 1 : $unsigned($random(seed)) % 24;
				if (i == 0)
					ch = md ? 17 : 23;
				if (ch == 16)
					ch = 17;
				v = 8'($unsigned($random(seed)) % 15 + 1);
				cur_m[ch] = cur_m[ch] ^ v[3:0];
				@(posedge aclk);
				sig_in <= '{1'b1, 5'(ch), cur_m[ch]};
				// Two equal samples, so a debounced channel takes the value too.
				repeat (2) @(posedge aclk);
				sig_in.valid <= 1'b0;
				repeat (2) @(negedge aclk);
				chk("irq low", interrupt_out_n, 1'b0);
				k = ch % 16;
				host.ind(1'b1, 7'h10 + 7'(k), v);
				chk("current pair", v, {cur_m[k], (md == 1 || k < 8) ? cur_m[k + 16] : 4'h0});
				pos = md ? (ch < 16 ? ch : ch - 1) : ch + 1;
				host.wr(IDX_CFG, 8'h63, r);
				host.rd(8'(IDX_DATA - (pos - 1) / 8), v, r);
				chk("flags", v, 8'(1 << ((pos - 1) % 8)) | (pos > 24 ? 8'h40 : 8'h00));
				host.rd(8'(IDX_DATA - (pos - 1) / 8), v, r);
				chk("flags cleared", v, pos > 24 ? 8'h40 : 8'h00);
				host.wr(IDX_CFG, 8'h23, r);
				@(negedge aclk);
				chk("irq high", interrupt_out_n, 1'b1);
			end
			// Two multiframe ticks move the last nibble into the delayed slot.
			repeat (2) begin
				@(posedge aclk);
				mf_tick <= 1'b1;
				@(posedge aclk);
				mf_tick <= 1'b0;
			end
			host.ind(1'b1, 7'h20 + 7'(ch), v);
			chk("delayed", v, {4'h0, cur_m[ch]});
			host.ind(1'b1, md ? 7'h10 : 7'h38, v);
			chk("empty slot", v, 8'h00);
			k = $unsigned($random(seed)) % 24;
			// Debounce stays on for this channel so the glitch case below means something.
			cv = 8'($random(seed)) | 8'h01;
			v = cv;
			host.ind(1'b0, 7'h40 + 7'(k), v);
			host.ind(1'b1, 7'h40 + 7'(k), v);
			chk("config readback", v, {4'h0, cv[3:0]});
			for (en = 0; en < 2; en++) begin
				host.wr(IDX_CFG, 8'h22 | 8'(en), r);
				for (i = 0; i < 6; i++) begin
					p = sxa_pcm_in_type'($random(seed));
					p.valid = 1'b1;
					p.ts = 5'(k);
					p.mw = p.mw & p.trunk;
					@(posedge aclk);
					pcm_in <= p;
					@(posedge aclk);
					@(negedge aclk);
					chk("pcm out", {pcm_out.valid, pcm_out.data},
						{1'b1, pexp(md[0], en ? cv[3:0] : 4'h0, sign_invert_ctl[k], p)});
				end
			end
			// One resync sample, then a one-sample glitch that debounce must reject.
			@(posedge aclk);
			sig_in <= '{1'b1, 5'(k), cur_m[k]};
			@(posedge aclk);
			sig_in.abcd <= ~cur_m[k];
			@(posedge aclk);
			sig_in.valid <= 1'b0;
			i = k % 16;
			host.ind(1'b1, 7'h10 + 7'(i), v);
			chk("glitch ignored", v,
				(md == 1 && i == 0) ? 8'h00 : {cur_m[i], (md == 1 || i < 8) ? cur_m[i + 16] : 4'h0});
			chk("glitch no irq", interrupt_out_n, 1'b1);
		end
		print_verdict();
	end

endmodule
